// ==== include/sram_port_consts.svh ====
// constants for the synchronous sram bus port
// assumes inclusion by bare name from the package and the design files
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

`define SRAM_ADDR_W     20
`define SRAM_LANES      2
`define SRAM_LANE_W     9
`define SRAM_BURST_W    2
`define SRAM_PAR_BIT    8

`define WB_ADR_W        4
`define WB_DAT_W        32
`define WB_SEL_W        4
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_MASK        4'h8
`define REG_STATE       4'hc

`define CTRL_ODD_BIT    0
`define EVT_W           2
`define EVT_PARITY_BIT  0
`define EVT_SLEEP_BIT   1
`define STATE_SLEEP_BIT 0
`define STATE_FLOW_BIT  1
`define SYNC_DEPTH      3

`endif

// ==== include/sram_port_pkg.sv ====
// types used by the sram bus port; its storage array does not use them
// assumes the constants header sits on the include path
`include "sram_port_consts.svh"

package sram_port_pkg;

  // one bus cycle as it travels down the read and write pipelines
  typedef struct packed {
    logic                        valid;
    logic                        write;
    logic [`SRAM_ADDR_W-1:0]     addr;
    logic [`SRAM_LANES-1:0]      lanes;
  } cmd_t;

endpackage

// ==== src/sram_store.sv ====
// byte-lane storage array with registered read data
// assumes one clock; write and read may hit the array in the same cycle
`timescale 1ns/10ps
`default_nettype none

module sram_store #(
  parameter int ADDR_W = 20,
  parameter int LANES  = 2,
  parameter int LANE_W = 9
) (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [LANES-1:0]        wr_lanes,
  input  wire logic [ADDR_W-1:0]       wr_addr,
  input  wire logic [LANES*LANE_W-1:0] wr_data,
  input  wire logic                    rd_en,
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output logic      [LANES*LANE_W-1:0] rd_data
);

  if (ADDR_W < 3 || LANES < 1 || LANE_W < 2) begin : g_bad_geometry
    $error("sram_store: unsupported geometry");
  end

  ////////////////////////////////////////////////////////////////////////////
  // one array per lane so a masked lane is simply not written
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      logic [LANE_W-1:0] cells [0:(1<<ADDR_W)-1];
      always_ff @(posedge clk) begin
        if (wr_en && wr_lanes[g]) begin
          cells[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
        end
        if (rd_en) begin
          rd_data[g*LANE_W +: LANE_W] <= cells[rd_addr];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== src/sram_port.sv ====
// synchronous late-write sram bus port with wishbone status registers
// assumes the host drives the sram pins from logic on CLK_SYS
//
// Functional notes
// - address, data and control are taken only at the rising clock edge
// - output enable pin turns data drivers off at once, any cycle
// - writes start at a clock edge and complete internally, no pulse
// - pipelined reads pass an output register before reaching the pins
// - reads and writes may follow each other with no idle cycle
// - write data follows command by two cycles pipelined, one flow-through
// - pipelined and flow-through read timing selected by a static pin
// - nine-bit byte lanes; only strobed lanes are written
// - burst order linear or interleaved from a pin held at a rail
// - write parity checked, even or odd; parity generated when unused
// - a cycle starts only with all three chip selects active
// - sleep request pin blocks cycles and drivers without the clock
// - burst step advances counter; low address bits preset it
// - clock enable high makes the edge ignored
// - with write strobe low, lanes with low byte strobes are written
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_consts.svh"

module sram_port #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES  = `SRAM_LANES,
  parameter int LANE_W = `SRAM_LANE_W
) (
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESET,
  input  wire logic [ADDR_W-1:0]         ADDR,
  input  wire logic [LANES*LANE_W-1:0]   DQ_IN,
  output logic      [LANES*LANE_W-1:0]   DQ_OUT,
  output logic                           DQ_OE,
  input  wire logic                      WRITE_N,
  input  wire logic [LANES-1:0]          BYTE_WRITE_N,
  input  wire logic                      CHIP_SELECT_1_N,
  input  wire logic                      CHIP_SELECT_2,
  input  wire logic                      CHIP_SELECT_3_N,
  input  wire logic                      OUTPUT_ENABLE_N,
  input  wire logic                      SLEEP_REQUEST,
  input  wire logic                      FLOW_THROUGH_SELECT,
  input  wire logic                      BURST_ORDER_SELECT,
  input  wire logic                      BURST_STEP,
  input  wire logic                      CLOCK_ENABLE_N,
  input  wire logic                      PARITY_LANE_SELECT,
  input  wire logic                      CYC_I,
  input  wire logic                      STB_I,
  input  wire logic                      WE_I,
  input  wire logic [`WB_ADR_W-1:0]      ADR_I,
  input  wire logic [`WB_DAT_W-1:0]      DAT_I,
  input  wire logic [`WB_SEL_W-1:0]      SEL_I,
  output logic      [`WB_DAT_W-1:0]      DAT_O,
  output logic                           ACK_O,
  output logic                           IRQ
);

  // the shared command type fixes the geometry at the header's values
  if (ADDR_W != `SRAM_ADDR_W || LANES != `SRAM_LANES ||
      LANE_W != `SRAM_LANE_W) begin : g_bad_geometry
    $error("sram_port: geometry must match the shared command type");
  end

  localparam int DW = LANES * LANE_W;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  sram_port_pkg::cmd_t last_reg, s1_reg, s2_reg, cur_cmd, wr_stage;
  logic [`SRAM_BURST_W-1:0] beat_reg;
  logic [`SRAM_BURST_W-1:0] beat_next;
  logic [`SRAM_BURST_W-1:0] base_lsb_reg;
  logic [`SRAM_BURST_W-1:0] lsb_next;

  wire        cke_ok   = !CLOCK_ENABLE_N;
  wire        selected = !CHIP_SELECT_1_N && CHIP_SELECT_2 &&
                         !CHIP_SELECT_3_N;
  wire        flow     = !FLOW_THROUGH_SELECT;
  // sleep gates the decode directly, so it acts without a clock edge
  wire        awake    = !SLEEP_REQUEST;
  wire        new_cmd  = cke_ok && awake && selected && !BURST_STEP;
  wire        cont_cmd = cke_ok && awake && BURST_STEP &&
                         last_reg.valid;
  wire        take     = new_cmd || cont_cmd;
  wire        is_write = new_cmd ? !WRITE_N : last_reg.write;
  wire        rd_take  = take && !is_write;
  wire        wr_take  = take && is_write;

  // counter wraps inside the aligned group of four
  assign beat_next = new_cmd ? '0 : beat_reg + 1'b1;
  assign lsb_next  = BURST_ORDER_SELECT ? (base_lsb_reg ^ beat_next)
                                        : (base_lsb_reg + beat_next);

  always_comb begin
    cur_cmd.valid = take;
    cur_cmd.write = is_write;
    if (new_cmd) begin
      cur_cmd.addr  = ADDR;
      cur_cmd.lanes = ~BYTE_WRITE_N;
    end else begin
      cur_cmd.addr  = {last_reg.addr[ADDR_W-1:`SRAM_BURST_W], lsb_next};
      cur_cmd.lanes = last_reg.lanes;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pipelines; a high clock enable freezes every stage
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      last_reg     <= '0;
      s1_reg       <= '0;
      s2_reg       <= '0;
      beat_reg     <= '0;
      base_lsb_reg <= '0;
    end else if (cke_ok) begin
      last_reg <= cur_cmd;
      s1_reg   <= cur_cmd;
      s2_reg   <= s1_reg;
      beat_reg <= beat_next;
      if (new_cmd) begin
        base_lsb_reg <= ADDR[`SRAM_BURST_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // late write with parity check or generation per lane
  logic [DW-1:0]    wr_data;
  logic [LANES-1:0] lane_bad;
  logic             odd_reg;

  // data lags its command by one stage flow-through, two pipelined
  assign wr_stage = flow ? s1_reg : s2_reg;
  wire   mem_we   = cke_ok && wr_stage.valid && wr_stage.write;
  wire   par_chk  = !PARITY_LANE_SELECT;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_par
      wire [LANE_W-1:0] lane = DQ_IN[g*LANE_W +: LANE_W];
      // unused ninth bit is filled so stored lanes always carry parity
      assign wr_data[g*LANE_W +: LANE_W] = par_chk ? lane :
        {(^lane[`SRAM_PAR_BIT-1:0]) ^ odd_reg,
         lane[`SRAM_PAR_BIT-1:0]};
      assign lane_bad[g] = par_chk && wr_stage.lanes[g] &&
                           ((^lane) != odd_reg);
    end
  endgenerate

  wire parity_evt = mem_we && (|lane_bad);

  logic [DW-1:0] mem_rd;

  sram_store #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_store (
    .clk      (CLK_SYS),
    .wr_en    (mem_we),
    .wr_lanes (wr_stage.lanes),
    .wr_addr  (wr_stage.addr),
    .wr_data  (wr_data),
    .rd_en    (rd_take),
    .rd_addr  (cur_cmd.addr),
    .rd_data  (mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read output path
  logic [DW-1:0] pipe_data_reg, dq_out_reg;
  logic          oe_reg;
  wire           s1_read = s1_reg.valid && !s1_reg.write;
  wire           s2_read = s2_reg.valid && !s2_reg.write;
  wire           oe_next = flow ? s1_read : s2_read;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pipe_data_reg <= '0;
      dq_out_reg    <= '0;
      oe_reg        <= 1'b0;
    end else if (cke_ok) begin
      if (s1_read) begin
        pipe_data_reg <= mem_rd;
      end
      if (flow && s1_read) begin
        dq_out_reg <= mem_rd;
      end else if (!flow && s2_read) begin
        dq_out_reg <= pipe_data_reg;
      end
      oe_reg <= oe_next;
    end
  end

  assign DQ_OUT = dq_out_reg;
  // the only combinational output: the enable pin must act without a clock
  assign DQ_OE  = oe_reg && !OUTPUT_ENABLE_N && awake;

  ////////////////////////////////////////////////////////////////////////////
  // sleep status through a three-stage synchroniser
  logic [`SYNC_DEPTH-1:0] sleep_q;
  logic                   sleep_state_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      sleep_q         <= '0;
      sleep_state_reg <= 1'b0;
    end else begin
      sleep_q <= {sleep_q[`SYNC_DEPTH-2:0], SLEEP_REQUEST};
      if (sleep_q[1] == sleep_q[2]) begin
        sleep_state_reg <= sleep_q[2];
      end
    end
  end

  wire sleep_evt = sleep_q[1] && sleep_q[2] && !sleep_state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: control, sticky status, mask, live state
  logic [`EVT_W-1:0]    status_reg, mask_reg;
  logic [`WB_DAT_W-1:0] dat_o_reg;
  logic                 ack_reg, irq_reg;

  wire       req      = CYC_I && STB_I && !ack_reg;
  // writes land at the edge where the master sees ack, data still held
  wire       wr_low   = CYC_I && STB_I && ack_reg && WE_I && SEL_I[0];
  wire       hit_ctrl = ADR_I == `REG_CTRL;
  wire       hit_stat = ADR_I == `REG_STATUS;
  wire       hit_mask = ADR_I == `REG_MASK;
  wire       hit_st   = ADR_I == `REG_STATE;
  wire [`EVT_W-1:0] evt_set = {sleep_evt, parity_evt};
  wire [`EVT_W-1:0] evt_clr = (wr_low && hit_stat) ?
                              DAT_I[`EVT_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [`EVT_W-1:0] status_next = (status_reg & ~evt_clr) | evt_set;
  wire [`WB_DAT_W-1:0] rd_mux =
    hit_ctrl ? {{(`WB_DAT_W-1){1'b0}}, odd_reg} :
    hit_stat ? {{(`WB_DAT_W-`EVT_W){1'b0}}, status_reg} :
    hit_mask ? {{(`WB_DAT_W-`EVT_W){1'b0}}, mask_reg} :
    hit_st   ? {{(`WB_DAT_W-2){1'b0}}, flow, sleep_state_reg} :
               '0;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      odd_reg    <= 1'b0;
      status_reg <= '0;
      mask_reg   <= '0;
      dat_o_reg  <= '0;
      ack_reg    <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      ack_reg    <= req;
      dat_o_reg  <= (req && !WE_I) ? rd_mux : '0;
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
      if (wr_low && hit_ctrl) begin
        odd_reg <= DAT_I[`CTRL_ODD_BIT];
      end
      if (wr_low && hit_mask) begin
        mask_reg <= DAT_I[`EVT_W-1:0];
      end
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_o_reg;
  assign IRQ   = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_oe_pin_off: assert property (@(posedge CLK_SYS) disable iff (RESET)
    OUTPUT_ENABLE_N |-> !DQ_OE)
    else $error("drivers on while output enable pin is off");

  a_select_gate: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (cke_ok && !selected && !BURST_STEP) |=> !s1_reg.valid)
    else $error("cycle started without all chip selects");

  a_sleep_block: assert property (@(posedge CLK_SYS) disable iff (RESET)
    SLEEP_REQUEST |-> (!take && !DQ_OE))
    else $error("activity during sleep request");

  a_turn_free: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (cke_ok && awake && selected && !BURST_STEP) |->
      (WRITE_N ? rd_take : wr_take))
    else $error("selected cycle not taken");

  a_ft_write_lag: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_take && flow) ##1 (cke_ok && flow) |-> mem_we)
    else $error("flow-through write not one cycle after command");

  a_pipe_write_lag: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_take && !flow) ##1 (cke_ok && !flow) ##1 (cke_ok && !flow)
      |-> mem_we)
    else $error("pipelined write not two cycles after command");

  a_ft_read_slot: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (rd_take && flow) ##1 (cke_ok && flow) |=> oe_reg)
    else $error("flow-through read slot missing");

  a_pipe_read_slot: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (rd_take && !flow) ##1 (cke_ok && !flow) ##1 (cke_ok && !flow)
      |=> (oe_reg && dq_out_reg == $past(pipe_data_reg)))
    else $error("pipelined read data not from output register");

  a_idle_undriven: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (cke_ok && !take && flow) ##1 (cke_ok && flow) |=> !oe_reg)
    else $error("drivers on in a deselected slot");

  a_parity_sticky: assert property (@(posedge CLK_SYS) disable iff (RESET)
    parity_evt |=> status_reg[`EVT_PARITY_BIT])
    else $error("parity error not recorded");

  a_burst_wrap: assert property (@(posedge CLK_SYS) disable iff (RESET)
    cont_cmd |-> cur_cmd.addr[ADDR_W-1:`SRAM_BURST_W] ==
                 last_reg.addr[ADDR_W-1:`SRAM_BURST_W])
    else $error("burst left its group of four");

endmodule

`default_nettype wire

// ==== verif/sram_host.sv ====
// host controller model driving the sram pins of the bus port
// assumes the bench calls op once per bus cycle from one process
`timescale 1ns/10ps
`default_nettype none

module sram_host (
  input  wire logic        clk,
  input  wire logic        pipe,
  output logic [19:0]      addr,
  output logic [17:0]      dq,
  output logic             wr_n,
  output logic [1:0]       bw_n,
  output logic [2:0]       cs,
  output logic             step,
  output logic             cke_n
);
  logic [17:0] wd1;
  logic [17:0] wd2;

  initial begin
    addr = 20'h0;
    dq = 18'h0;
    wr_n = 1'b1;
    bw_n = 2'h3;
    cs = 3'h0;
    step = 1'b0;
    cke_n = 1'b0;
    wd1 = 18'h0;
    wd2 = 18'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // c packs {select 3 low, select 2 high, select 1 low} as {c2, c1, c0}
  task automatic op(input logic w, input logic [19:0] a,
                    input logic [1:0] b, input logic [17:0] d,
                    input logic [2:0] c, input logic s, input logic k);
    @(posedge clk);
    addr <= a;
    wr_n <= ~w;
    bw_n <= b;
    cs <= c;
    step <= s;
    cke_n <= k;
    wd1 <= d;
  endtask

  // data trails its command; on read slots it is junk that keeps changing
  always @(posedge clk) begin
    wd2 <= wd1;
    dq <= pipe ? wd2 : wd1;
  end
endmodule
`default_nettype wire

// ==== verif/sram_port_tb.sv ====
// self-checking bench for the sram bus port
// assumes sram_host drives the sram pins; wishbone master lives here
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_consts.svh"

module sram_port_tb;
  logic        clk, rst, oe_n, slp, pipe, ilv, cyc, stb, we, tq, gen;
  logic [3:0]  adr;
  logic [31:0] wdat, q;
  wire  [31:0] rdat;
  wire         ack, irq, dq_oe, wr_n, step, cke_n;
  wire  [19:0] a;
  wire  [17:0] dqi, dqo;
  wire  [1:0]  bw_n;
  wire  [2:0]  cs;
  logic        ev [0:3];
  logic [17:0] ed [0:3];
  logic [17:0] mem [0:63];
  logic [19:0] base;
  logic [1:0]  beat, bb;
  logic        bw;
  logic [15:0] lfsr;
  int          mismatches, total_checks, cycles;

  sram_port sram_port_inst (.CLK_SYS(clk), .RESET(rst), .ADDR(a),
    .DQ_IN(dqi), .DQ_OUT(dqo), .DQ_OE(dq_oe), .WRITE_N(wr_n),
    .BYTE_WRITE_N(bw_n), .CHIP_SELECT_1_N(cs[0]), .CHIP_SELECT_2(cs[1]),
    .CHIP_SELECT_3_N(cs[2]), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(slp),
    .FLOW_THROUGH_SELECT(pipe), .BURST_ORDER_SELECT(ilv),
    .BURST_STEP(step), .CLOCK_ENABLE_N(cke_n), .PARITY_LANE_SELECT(gen),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .DAT_I(wdat),
    .SEL_I(4'hf), .DAT_O(rdat), .ACK_O(ack), .IRQ(irq));
  sram_host sram_host_inst (.clk(clk), .pipe(pipe), .addr(a), .dq(dqi),
    .wr_n(wr_n), .bw_n(bw_n), .cs(cs), .step(step), .cke_n(cke_n));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // even parity per lane, bit 8 of each lane
  function automatic logic [17:0] par(input logic [15:0] x);
    par = {^x[15:8], x[15:8], ^x[7:0], x[7:0]};
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one bus cycle; the read slot due at this edge is checked first
  task automatic go(input logic w, input logic [19:0] ad,
                    input logic [1:0] b, input logic [17:0] d,
                    input logic [2:0] c, input logic s, input logic k);
    logic        t;
    logic [19:0] ea;
    sram_host_inst.op(w, ad, b, d, c, s, k);
    if (oe_n === 1'b0) begin
      chk("slot", 32'(ev[pipe ? 3 : 2]), 32'(dq_oe));
      if (ev[pipe ? 3 : 2])
        chk("rdata", 32'(ed[pipe ? 3 : 2]), 32'(dqo));
    end else
      chk("oe off", 32'h0, 32'(dq_oe));
    t = !k && !slp && (s ? tq : c == 3'b010);
    if (t && !s) begin
      base = ad;
      beat = 2'h0;
      bw = w;
      bb = b;
    end else if (t)
      beat = beat + 2'h1;
    ea = {base[19:2], ilv ? base[1:0] ^ beat : base[1:0] + beat};
    if (t && bw)
      mem[ea[5:0]] = {bb[1] ? mem[ea[5:0]][17:9] : d[17:9],
                      bb[0] ? mem[ea[5:0]][8:0] : d[8:0]};
    for (int i = 3; i > 0; i--) begin
      ev[i] = ev[i-1];
      ed[i] = ed[i-1];
    end
    ev[0] = t && !bw;
    ed[0] = mem[ea[5:0]];
    tq = t;
  endtask

  task automatic idle(input int n);
    repeat (n) go(1'b0, 20'h0, 2'h0, ~dqi, 3'b000, 1'b0, 1'b0);
  endtask

  task automatic wb(input logic w, input logic [3:0] ad,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
      mismatches++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // random mix: writes to 16..31, reads of 0..15, steps, deselects
  task automatic mix(input int n);
    logic [15:0] r;
    for (int i = 0; i < n; i++) begin
      lfsr = nx(lfsr);
      r = lfsr;
      oe_n <= r[9] & r[10];
      case (r[1:0])
        2'h0: go(1'b1, {16'h1, r[5:2]}, r[7:6], par(r ^ 16'h5a3c),
                 3'b010, 1'b0, 1'b0);
        2'h1: go(1'b0, {16'h0, r[5:2]}, 2'h0, par(r), 3'b010, 1'b0, 1'b0);
        2'h2: go(1'b0, 20'h0, 2'h0, par(r), 3'b010, tq, 1'b0);
        default: go(1'b0, 20'h0, 2'h0, par(r),
                    (r[4:2] == 3'b010) ? 3'b000 : r[4:2], 1'b0, 1'b0);
      endcase
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    {rst, oe_n, slp, pipe, ilv, cyc, stb, we, tq} = 9'h100;
    adr = 4'h0;
    wdat = 32'h0;
    lfsr = 16'h0023;
    gen = 1'b0;
    for (int m = 0; m < 4; m++) begin
      pipe <= m[0];
      ilv <= m[1]; // held steady while traffic runs
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
        ev[i] = 1'b0;
      tq = 1'b0;
      for (int i = 0; i < 32; i++) begin
        lfsr = nx(lfsr);
        go(1'b1, 20'(i), 2'h0, par(lfsr), 3'b010, 1'b0, 1'b0);
      end
      mix(80);
      oe_n <= 1'b0;
      idle(4);
      for (int i = 0; i < 32; i++)
        go(1'b0, 20'(i), 2'h0, ~dqi, 3'b010, 1'b0, 1'b0);
      idle(4);
      // edge ignored: the write must not land
      go(1'b1, 20'h2, 2'h0, 18'h0, 3'b010, 1'b0, 1'b1);
      idle(4);
      go(1'b0, 20'h2, 2'h0, 18'h0, 3'b010, 1'b0, 1'b0);
      idle(5);
      wb(1'b1, `REG_MASK, 32'h3);
      wb(1'b1, `REG_CTRL, 32'h1);
      go(1'b1, 20'h28, 2'h0, par(16'h1234), 3'b010, 1'b0, 1'b0);
      idle(6);
      wb(1'b1, `REG_CTRL, 32'h0);
      chk("irq set", 32'h1, 32'(irq));
      wb(1'b0, `REG_STATUS, 32'h0);
      chk("status", 32'h1, q);
      wb(1'b1, `REG_STATUS, 32'h1);
      wb(1'b0, `REG_STATUS, 32'h0);
      chk("w1c", 32'h0, q);
      chk("irq clr", 32'h0, 32'(irq));
      // generation mode: a wrong ninth bit is replaced, no error flagged
      gen <= 1'b1;
      go(1'b1, 20'h29, 2'h0, par(16'h00a5) ^ 18'h100, 3'b010, 1'b0, 1'b0);
      mem[6'h29] = par(16'h00a5);
      idle(4);
      gen <= 1'b0;
      go(1'b0, 20'h29, 2'h0, 18'h0, 3'b010, 1'b0, 1'b0);
      idle(5);
      slp <= 1'b1;
      go(1'b0, 20'h0, 2'h0, 18'h0, 3'b010, 1'b0, 1'b0);
      idle(6);
      wb(1'b0, `REG_STATE, 32'h0);
      chk("state", {30'h0, ~m[0], 1'b1}, q);
      wb(1'b0, `REG_STATUS, 32'h0);
      chk("sleep evt", 32'h2, q);
      chk("irq slp", 32'h1, 32'(irq));
      wb(1'b1, `REG_MASK, 32'h1);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
      chk("irq mask", 32'h0, 32'(irq));
      slp <= 1'b0;
      wb(1'b1, `REG_STATUS, 32'h3);
    end
    final_report();
  end
endmodule
`default_nettype wire
